// ===== trace_owner_consts.vh
// Constants for the data and ownership trace block.
// Assumes inclusion by the block's single design file.
`ifndef TRACE_OWNER_CONSTS_VH
`define TRACE_OWNER_CONSTS_VH

`define REG_SEL_W          3
`define REG_CTRL           3'h0
`define REG_SA0            3'h1
`define REG_EA0            3'h2
`define REG_SA1            3'h3
`define REG_EA1            3'h4
`define REG_PID            3'h5

`define CTRL_RW_TRACE_ENABLE_CH0_HI       31
`define CTRL_RW_TRACE_ENABLE_CH0_LO       30
`define CTRL_RW_TRACE_ENABLE_CH1_HI       29
`define CTRL_RW_TRACE_ENABLE_CH1_LO       28
`define CTRL_SID1_HI       19
`define CTRL_SID1_LO       12
`define CTRL_SID1EN        11
`define CTRL_SID0_HI       10
`define CTRL_SID0_LO       3
`define CTRL_SID0EN        2
`define CTRL_WP1           1
`define CTRL_WP0           0
`define CTRL_WMASK         32'hF00FFFFF
`define REG_RESET          32'h00000000

`define CODE_OWNER         6'h02
`define CODE_DREAD         6'h06
`define CODE_DWRITE        6'h05
`define CODE_ERROR         6'h08
`define PERIOD_MSGS        9'h100

`endif

// ===== data_owner_trace.v
// Data trace channel filters and ownership trace message generation.
// Assumes a single MCLK domain; the message sink presents msg_ready.
//
// Notes on behaviour
// - Two-bit read/write enable field per channel.
// - Channel 1 identifier bits 19:12, enable bit 11.
// - Channel 0 identifier bits 10:3, enable bit 2.
// - Watchpoint bits 0 and 1, read/write, reset zero.
// - Match only when address inside inclusive range.
// - Each channel has own start/end registers.
// - Equal start and end matches one address.
// - Start above end never matches.
// - Owner message: 32-bit identifier, code 2.
// - Identifier write triggers owner message.
// - Owner message at least every 256 messages.
// - Owner messages only while trace mode bit set.
// - Program sync overflow also sends owner message.
// - Data sync overflow also sends owner message.
// - Write during full queue resent after overrun.
// - No room and no halt gives error message.
// - Privileged CPU writes identifier via debug move.
// - Matching enabled read emits code 6 message.
`timescale 1ns/100ps
`default_nettype none
`include "trace_owner_consts.vh"

module data_owner_trace
(
  input  wire        MCLK,
  input  wire        RST_N,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [2:0]  REG_SEL,
  input  wire [31:0] REG_WDATA,
  input  wire        CPU_PRIV,
  output reg  [31:0] REG_RDATA,
  input  wire        TRACE_MODE0,
  input  wire        HALT_ON_OVERRUN,
  input  wire        PROG_SYNC_OVF,
  input  wire        DATA_SYNC_OVF,
  input  wire        PROG_MSG_SENT,
  input  wire        ACC_VALID,
  input  wire        ACC_WRITE,
  input  wire [31:0] ACC_ADDR,
  input  wire [7:0]  ACC_SPACE_ID,
  output reg  [1:0]  CH_MATCH,
  output wire [1:0]  WATCHPOINT_HIT,
  output reg         MSG_VALID,
  input  wire        MSG_READY,
  output reg  [5:0]  MSG_CODE,
  output reg  [31:0] MSG_DATA,
  output wire        CPU_HALT_REQ
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  reg rst_meta_q;
  reg rst_n_q;
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [31:0] ctrl_q;
  reg [31:0] sa0_q;
  reg [31:0] ea0_q;
  reg [31:0] sa1_q;
  reg [31:0] ea1_q;
  reg [31:0] pid_q;

  // Identifier writes are accepted from privileged CPU modes only.
  wire pid_wr = REG_WR && (REG_SEL == `REG_PID) && CPU_PRIV;

  // Next register values; a write takes effect on the edge of its strobe.
  reg [31:0] ctrl_d;
  reg [31:0] sa0_d;
  reg [31:0] ea0_d;
  reg [31:0] sa1_d;
  reg [31:0] ea1_d;
  reg [31:0] pid_d;

  always @*
  begin
    ctrl_d = ctrl_q;
    sa0_d  = sa0_q;
    ea0_d  = ea0_q;
    sa1_d  = sa1_q;
    ea1_d  = ea1_q;
    pid_d  = pid_q;
    if (REG_WR)
    begin
      case (REG_SEL)
        `REG_CTRL: ctrl_d = REG_WDATA & `CTRL_WMASK;
        `REG_SA0:  sa0_d  = REG_WDATA;
        `REG_EA0:  ea0_d  = REG_WDATA;
        `REG_SA1:  sa1_d  = REG_WDATA;
        `REG_EA1:  ea1_d  = REG_WDATA;
        `REG_PID:  if (CPU_PRIV) pid_d = REG_WDATA;
        default:   ctrl_d = ctrl_q;
      endcase
    end
  end

  always @(posedge MCLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q <= `REG_RESET;
      sa0_q  <= `REG_RESET;
      ea0_q  <= `REG_RESET;
      sa1_q  <= `REG_RESET;
      ea1_q  <= `REG_RESET;
      pid_q  <= `REG_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      sa0_q  <= sa0_d;
      ea0_q  <= ea0_d;
      sa1_q  <= sa1_d;
      ea1_q  <= ea1_d;
      pid_q  <= pid_d;
    end
  end

  // ------------------------------------------------------------
  // Register read-back
  // ------------------------------------------------------------
  // Read data is held between reads so a slow reader sees a stable word.
  reg [31:0] rdata_d;

  always @*
  begin
    rdata_d = REG_RDATA;
    if (REG_RD)
    begin
      case (REG_SEL)
        `REG_CTRL: rdata_d = ctrl_q;
        `REG_SA0:  rdata_d = sa0_q;
        `REG_EA0:  rdata_d = ea0_q;
        `REG_SA1:  rdata_d = sa1_q;
        `REG_EA1:  rdata_d = ea1_q;
        `REG_PID:  rdata_d = pid_q;
        default:   rdata_d = `REG_RESET;
      endcase
    end
  end

  always @(posedge MCLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      REG_RDATA <= `REG_RESET;
    else
      REG_RDATA <= rdata_d;
  end

  // ------------------------------------------------------------
  // Channel match
  // ------------------------------------------------------------
  function chan_match;
    input [1:0]  rw_en;
    input        sid_en;
    input [7:0]  sid;
    input [31:0] sa;
    input [31:0] ea;
    input        wr;
    input [31:0] addr;
    input [7:0]  cur_sid;
    reg dir_ok;
    reg rng_ok;
    begin
      dir_ok     = wr ? rw_en[1] : rw_en[0];
      // A reversed range can never satisfy both bounds.
      rng_ok     = (addr >= sa) && (addr <= ea);
      chan_match = dir_ok && rng_ok && (!sid_en || (sid == cur_sid));
    end
  endfunction

  wire m0 = chan_match(ctrl_q[`CTRL_RW_TRACE_ENABLE_CH0_HI:`CTRL_RW_TRACE_ENABLE_CH0_LO], ctrl_q[`CTRL_SID0EN],
                       ctrl_q[`CTRL_SID0_HI:`CTRL_SID0_LO], sa0_q, ea0_q,
                       ACC_WRITE, ACC_ADDR, ACC_SPACE_ID);
  wire m1 = chan_match(ctrl_q[`CTRL_RW_TRACE_ENABLE_CH1_HI:`CTRL_RW_TRACE_ENABLE_CH1_LO], ctrl_q[`CTRL_SID1EN],
                       ctrl_q[`CTRL_SID1_HI:`CTRL_SID1_LO], sa1_q, ea1_q,
                       ACC_WRITE, ACC_ADDR, ACC_SPACE_ID);
  wire data_hit = ACC_VALID && (m0 || m1);

  reg [1:0] ch_match_d;

  always @*
  begin
    ch_match_d = 2'h0;
    if (ACC_VALID)
      ch_match_d = {m1, m0};
  end

  always @(posedge MCLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      CH_MATCH <= 2'h0;
    else
      CH_MATCH <= ch_match_d;
  end

  assign WATCHPOINT_HIT = CH_MATCH & {ctrl_q[`CTRL_WP1], ctrl_q[`CTRL_WP0]};

  // ------------------------------------------------------------
  // Owner message scheduling
  // ------------------------------------------------------------
  reg        own_pend_q;
  reg        own_pend_d;
  reg        err_pend_q;
  reg        err_pend_d;
  reg  [8:0] period_q;
  reg  [8:0] period_d;
  reg        msg_valid_d;
  reg  [5:0] msg_code_d;
  reg [31:0] msg_data_d;
  wire       slot_busy  = MSG_VALID && !MSG_READY;
  wire       period_hit = (period_q >= `PERIOD_MSGS);
  wire       sync_ovf   = PROG_SYNC_OVF || DATA_SYNC_OVF;
  wire       own_trig   = TRACE_MODE0 && (pid_wr || sync_ovf || period_hit);
  wire       msg_cnt    = PROG_MSG_SENT || (data_hit && TRACE_MODE0);

  // Holding the core while the queue is full lets the message wait.
  assign CPU_HALT_REQ = HALT_ON_OVERRUN && own_pend_q && slot_busy;

  // Priority is error, then owner, then data; a full slot holds its message.
  always @*
  begin
    own_pend_d  = own_pend_q;
    err_pend_d  = err_pend_q;
    period_d    = period_q;
    msg_valid_d = MSG_VALID;
    msg_code_d  = MSG_CODE;
    msg_data_d  = MSG_DATA;
    // A second trigger while one owner message already waits behind a full slot is an overrun unless halting on overrun.
    if (own_trig && own_pend_q && slot_busy && !HALT_ON_OVERRUN)
      err_pend_d = 1'b1;
    if (slot_busy)
      own_pend_d = own_pend_q || own_trig;
    else if (err_pend_q)
    begin
      msg_valid_d = 1'b1;
      msg_code_d  = `CODE_ERROR;
      msg_data_d  = `REG_RESET;
      err_pend_d  = 1'b0;
      own_pend_d  = own_pend_q || own_trig;
    end
    else if (own_pend_q || own_trig)
    begin
      msg_valid_d = 1'b1;
      msg_code_d  = `CODE_OWNER;
      msg_data_d  = pid_wr ? REG_WDATA : pid_q;
      own_pend_d  = 1'b0;
    end
    else if (data_hit)
    begin
      msg_valid_d = 1'b1;
      msg_code_d  = ACC_WRITE ? `CODE_DWRITE : `CODE_DREAD;
      msg_data_d  = ACC_ADDR;
    end
    else
    begin
      msg_valid_d = 1'b0;
    end
    // Every trigger restarts the count, so a saturated count fires only once.
    if (own_trig)
      period_d = 9'h000;
    else if (msg_cnt && !period_hit)
      period_d = period_q + 9'h001;
  end

  always @(posedge MCLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      own_pend_q <= 1'b0;
      err_pend_q <= 1'b0;
      period_q   <= 9'h000;
      MSG_VALID  <= 1'b0;
      MSG_CODE   <= 6'h00;
      MSG_DATA   <= `REG_RESET;
    end
    else
    begin
      own_pend_q <= own_pend_d;
      err_pend_q <= err_pend_d;
      period_q   <= period_d;
      MSG_VALID  <= msg_valid_d;
      MSG_CODE   <= msg_code_d;
      MSG_DATA   <= msg_data_d;
    end
  end

endmodule
`default_nettype wire

// ===== data_owner_trace_asserts.sv
// Checker for the trace block's match, message and halt outputs.
// Assumes binding to data_owner_trace in a single MCLK domain.
`timescale 1ns/100ps
`default_nettype none
module data_owner_trace_asserts
(
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        REG_WR,
  input wire logic [2:0]  REG_SEL,
  input wire logic [31:0] REG_WDATA,
  input wire logic        CPU_PRIV,
  input wire logic        TRACE_MODE0,
  input wire logic        HALT_ON_OVERRUN,
  input wire logic        PROG_SYNC_OVF,
  input wire logic        DATA_SYNC_OVF,
  input wire logic        ACC_VALID,
  input wire logic [1:0]  CH_MATCH,
  input wire logic [1:0]  WATCHPOINT_HIT,
  input wire logic        MSG_VALID,
  input wire logic        MSG_READY,
  input wire logic [5:0]  MSG_CODE,
  input wire logic [31:0] MSG_DATA,
  input wire logic        CPU_HALT_REQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  AST_OWN: assert property (
    REG_WR && REG_SEL == 3'h5 && CPU_PRIV && TRACE_MODE0 && !MSG_VALID |=>
    MSG_VALID && MSG_CODE == 6'h02 && MSG_DATA == $past(REG_WDATA)) else $error("own");
  AST_OFF: assert property (
    !TRACE_MODE0 && !MSG_VALID |=> !MSG_VALID || MSG_CODE != 6'h02) else $error("off");
  AST_HOLD: assert property (
    MSG_VALID && !MSG_READY |=> MSG_VALID && $stable({MSG_CODE, MSG_DATA})) else $error("hold");
  AST_PSYNC: assert property (
    PROG_SYNC_OVF && TRACE_MODE0 && !MSG_VALID ##1 1'b1 |-> MSG_CODE == 6'h02) else $error("ps");
  AST_DSYNC: assert property (
    DATA_SYNC_OVF && TRACE_MODE0 && !MSG_VALID |=> $rose(MSG_VALID)) else $error("ds");
  AST_WP: assert property (
    (WATCHPOINT_HIT & ~CH_MATCH) == 2'b00) else $error("wp");
  AST_MATCH: assert property (
    CH_MATCH != 2'b00 |-> $past(ACC_VALID)) else $error("match");
  AST_HALT: assert property (
    CPU_HALT_REQ |-> HALT_ON_OVERRUN && MSG_VALID && !MSG_READY) else $error("halt");
  AST_ERR: assert property (
    MSG_VALID && MSG_CODE == 6'h08 |-> MSG_DATA == 32'h00000000) else $error("err");
endmodule
bind data_owner_trace data_owner_trace_asserts i_chk
(
  .MCLK(MCLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA),
  .CPU_PRIV(CPU_PRIV), .TRACE_MODE0(TRACE_MODE0), .HALT_ON_OVERRUN(HALT_ON_OVERRUN),
  .PROG_SYNC_OVF(PROG_SYNC_OVF), .DATA_SYNC_OVF(DATA_SYNC_OVF), .ACC_VALID(ACC_VALID),
  .CH_MATCH(CH_MATCH), .WATCHPOINT_HIT(WATCHPOINT_HIT), .MSG_VALID(MSG_VALID),
  .MSG_READY(MSG_READY), .MSG_CODE(MSG_CODE), .MSG_DATA(MSG_DATA),
  .CPU_HALT_REQ(CPU_HALT_REQ)
);
`default_nettype wire

// ===== trace_sink_model.sv
// Trace sink standing in for the debug tool; it stalls on command.
// Assumes the bench drives stall on rising edges.
`timescale 1ns/100ps
`default_nettype none
module trace_sink_model
(
  input  wire logic MCLK,
  input  wire logic stall,
  output var  logic msg_ready
);
  logic ready_q = 1'b0;
  // Alternating acceptance when not stalled, so slow and prompt takes both occur.
  always @(posedge MCLK)
    ready_q <= !stall && !ready_q;
  assign msg_ready = ready_q;
endmodule
`default_nettype wire

// ===== tb_data_owner_trace.sv
// Bench for data_owner_trace: registers, channel matches and owner messages.
// Assumes the checker is bound and the sink model is compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module tb_data_owner_trace;
  logic        MCLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, CPU_PRIV = 1, stall = 0;
  logic        TRACE_MODE0 = 0, HALT_ON_OVERRUN = 0, PROG_SYNC_OVF = 0, DATA_SYNC_OVF = 0;
  logic        PROG_MSG_SENT = 0, ACC_VALID = 0, ACC_WRITE = 0;
  logic [2:0]  REG_SEL = 0;
  logic [7:0]  ACC_SPACE_ID = 0;
  logic [31:0] REG_WDATA = 0, ACC_ADDR = 0, v;
  wire  [31:0] REG_RDATA, MSG_DATA;
  wire  [5:0]  MSG_CODE;
  wire  [1:0]  CH_MATCH, WATCHPOINT_HIT;
  wire         MSG_VALID, MSG_READY, CPU_HALT_REQ;
  logic [37:0] notes[$];
  int          bad_count = 0, checks = 0, cyc = 0, seed = 32'h3FB3;
  data_owner_trace i_data_owner_trace
  (
    .MCLK(MCLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_SEL(REG_SEL),
    .REG_WDATA(REG_WDATA), .CPU_PRIV(CPU_PRIV), .REG_RDATA(REG_RDATA),
    .TRACE_MODE0(TRACE_MODE0), .HALT_ON_OVERRUN(HALT_ON_OVERRUN),
    .PROG_SYNC_OVF(PROG_SYNC_OVF), .DATA_SYNC_OVF(DATA_SYNC_OVF),
    .PROG_MSG_SENT(PROG_MSG_SENT), .ACC_VALID(ACC_VALID), .ACC_WRITE(ACC_WRITE),
    .ACC_ADDR(ACC_ADDR), .ACC_SPACE_ID(ACC_SPACE_ID), .CH_MATCH(CH_MATCH),
    .WATCHPOINT_HIT(WATCHPOINT_HIT), .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY),
    .MSG_CODE(MSG_CODE), .MSG_DATA(MSG_DATA), .CPU_HALT_REQ(CPU_HALT_REQ)
  );
  trace_sink_model i_trace_sink_model (.MCLK(MCLK), .stall(stall), .msg_ready(MSG_READY));
  initial forever #50 MCLK = ~MCLK;
  task automatic cmp(input logic [37:0] got, input logic [37:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("bad_count %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge MCLK);
    REG_WR    <= 1'b1;
    REG_SEL   <= s;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [31:0] e);
    @(posedge MCLK);
    REG_RD  <= 1'b1;
    REG_SEL <= s;
    @(posedge MCLK);
    REG_RD  <= 1'b0;
    @(negedge MCLK);
    cmp(REG_RDATA, e);
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] id, input logic e);
    @(posedge MCLK);
    ACC_VALID    <= 1'b1;
    ACC_WRITE    <= w;
    ACC_ADDR     <= a;
    ACC_SPACE_ID <= id;
    if (e)
      notes.push_back({6'h06, a});
    @(posedge MCLK);
    ACC_VALID <= 1'b0;
    @(negedge MCLK);
    cmp(CH_MATCH, {1'b0, e});
    cmp(WATCHPOINT_HIT, {1'b0, e});
  endtask
  task automatic owner_process_id(input logic [31:0] d);
    notes.push_back({6'h02, d});
    wr(3'h5, d);
  endtask
  // Message watcher pairs each accepted message with the oldest note.
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (MSG_VALID === 1'b1 && MSG_READY === 1'b1)
      cmp({MSG_CODE, MSG_DATA}, notes.size() ? notes.pop_front() : 38'h3F_FFFF_FFFF);
    if (cyc == 3000)
    begin
      cmp(38'h0, 38'h1);
      final_report();
    end
  end
  initial
  begin
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    for (int i = 0; i < 6; i++) rd(i[2:0], 32'h0);
    wr(3'h0, 32'hFFFFFFFF);
    rd(3'h0, 32'hF00FFFFF);
    for (int i = 1; i < 5; i++) wr(i[2:0], 32'h100 * i);
    for (int i = 1; i < 5; i++) rd(i[2:0], 32'h100 * i);
    wr(3'h2, 32'h100);
    wr(3'h3, 32'h500);
    wr(3'h0, 32'h700002D5);
    acc(1'b0, 32'h100, 8'h5A, 1'b1);
    acc(1'b0, 32'h101, 8'h5A, 1'b0);
    acc(1'b1, 32'h100, 8'h5A, 1'b0);
    acc(1'b0, 32'h100, 8'hA5, 1'b0);
    acc(1'b1, 32'h400 + ($random(seed) & 32'hFF), 8'h00, 1'b0);
    @(posedge MCLK);
    TRACE_MODE0 <= 1'b1;
    v = $random(seed);
    owner_process_id(v);
    CPU_PRIV <= 1'b0;
    wr(3'h5, ~v);
    CPU_PRIV <= 1'b1;
    rd(3'h5, v);
    @(posedge MCLK);
    TRACE_MODE0 <= 1'b0;
    wr(3'h5, v + 1);
    TRACE_MODE0 <= 1'b1;
    rd(3'h5, v + 1);
    for (int k = 0; k < 2; k++)
    begin
      notes.push_back({6'h02, v + 1});
      @(posedge MCLK);
      {PROG_SYNC_OVF, DATA_SYNC_OVF} <= 2'b10 >> k;
      @(posedge MCLK);
      {PROG_SYNC_OVF, DATA_SYNC_OVF} <= 2'b00;
      repeat (8) @(posedge MCLK);
    end
    notes.push_back({6'h02, v + 1});
    repeat (256)
    begin
      @(posedge MCLK);
      PROG_MSG_SENT <= 1'b1;
      @(posedge MCLK);
      PROG_MSG_SENT <= 1'b0;
    end
    for (int h = 0; h < 2; h++)
    begin
      repeat (20) @(posedge MCLK);
      stall           <= 1'b1;
      HALT_ON_OVERRUN <= h[0];
      repeat (3) @(posedge MCLK);
      owner_process_id(v + 2);
      wr(3'h5, v + 3);
      wr(3'h5, v + 4);
      if (h == 0)
        notes.push_back({6'h08, 32'h00000000});
      notes.push_back({6'h02, v + 4});
      @(negedge MCLK);
      cmp(CPU_HALT_REQ, h[0]);
      @(posedge MCLK);
      stall <= 1'b0;
    end
    repeat (20) @(posedge MCLK);
    cmp(notes.size(), 38'h0);
    final_report();
  end
endmodule
`default_nettype wire
